// *** hdl/dtc_pkg.sv ***
// shared types, timing figures and cycle counts for the dram cycle controller
package dtc_pkg;

  // ==========================================================================
  // clock and helpers
  localparam int CLK_NS = 8;                  // sys_clk period at 125 mhz

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ==========================================================================
  // timing figures as printed, fastest grade
  localparam int INIT_PAUSE_US   = 200;
  localparam int INIT_CBR_COUNT  = 8;
  localparam int REF_WINDOW_US   = 8200;      // 8.2 ms
  localparam int REF_ROWS        = 512;
  localparam int RAS_MAX_NS      = 100000;
  localparam int RAS_MIN_NS      = 60;
  localparam int RP_NS           = 40;
  localparam int RAH_NS          = 10;
  localparam int RCD_MIN_NS      = 20;
  localparam int RAC_NS          = 60;
  localparam int CAS_MIN_NS      = 15;
  localparam int CWL_NS          = 12;
  localparam int RWL_NS          = 15;
  localparam int WCH_NS          = 10;
  localparam int CP_NS           = 10;
  localparam int PC_NS           = 40;
  localparam int CHR_NS          = 10;
  localparam int CSR_NS          = 0;
  localparam int CPN_NS          = 10;
  localparam int OED_NS          = 15;
  localparam int OEL_NS          = 10;
  localparam int SYNC_LAT        = 4;         // pin to settled sample, edges

  // ==========================================================================
  // derived cycle counts
  localparam int INIT_PAUSE_DFLT = INIT_PAUSE_US * 1000 / CLK_NS;
  localparam int RAS_MAX_DFLT    = RAS_MAX_NS / CLK_NS;
  localparam int REF_INT_CYC     = REF_WINDOW_US * 1000 / REF_ROWS / CLK_NS;
  localparam int RAS_MIN_CYC     = cyc_up(RAS_MIN_NS);
  localparam int PRE_CYC         = max2(cyc_up(RP_NS), cyc_up(CPN_NS));
  localparam int RCD_CYC         = cyc_up(RCD_MIN_NS);
  localparam int ROW_WAIT        = max2(cyc_up(RAH_NS), RCD_CYC - 1);
  localparam int WR_CAS_CYC      = max2(max2(cyc_up(CAS_MIN_NS),
                                             cyc_up(CWL_NS)),
                                        max2(cyc_up(WCH_NS),
                                             cyc_up(RWL_NS)));
  localparam int RD_CAS_CYC      = cyc_up(RAC_NS) - (ROW_WAIT + 1)
                                   + SYNC_LAT;
  localparam int GAP_CYC         = max2(max2(cyc_up(CP_NS), cyc_up(OED_NS)),
                                        cyc_up(OEL_NS));
  localparam int PC_CYC          = cyc_up(PC_NS);
  localparam int CSR_CYC         = cyc_up(CSR_NS);
  localparam int CBR_LOW_CYC     = max2(RAS_MIN_CYC, cyc_up(CHR_NS));

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       write;
    logic [8:0] row;
    logic [8:0] col;
    logic [3:0] wdata;
  } dtc_req_t;

  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       oe_n;
    logic [8:0] multiplexed_address;
    logic [3:0] data_pins_out;
    logic       data_pins_oe_n;
  } dtc_pins_t;

  localparam dtc_pins_t PINS_RESET = '{ras_n: 1'b1, cas_n: 1'b1,
                                       we_n: 1'b1, oe_n: 1'b1,
                                       multiplexed_address: 9'h000,
                                       data_pins_out: 4'h0,
                                       data_pins_oe_n: 1'b1};

  typedef enum logic [3:0] {
    ST_PAUSE   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_ROW     = 4'h2,
    ST_RAS_ACT = 4'h3,
    ST_COL_SET = 4'h4,
    ST_COL_LOW = 4'h5,
    ST_COL_HI  = 4'h6,
    ST_PRECHG  = 4'h7,
    ST_CBR_CAS = 4'h8,
    ST_CBR_RAS = 4'h9
  } dtc_state_t;

endpackage : dtc_pkg

// *** hdl/dtc_sync.sv ***
// three-stage input synchroniser with agreement filter for the data pins
`timescale 1ns/1ns
module dtc_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // pin side
  input  wire logic [W-1:0] pin,
  // settled value
  output logic      [W-1:0] val
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } dtc_sync_st_t;

  dtc_sync_st_t s;
  dtc_sync_st_t next_s;

  // ==========================================================================
  // stage chain; s1 only feeds s2, a bit counts once s2 and s3 agree
  always_comb begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      next_s.val[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.val[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign val = s.val;

endmodule : dtc_sync

// *** hdl/dtc_fifo.sv ***
// request fifo with registered ready; depth must be a power of two
`timescale 1ns/1ns
module dtc_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          rdy;
  } dtc_fifo_st_t;

  dtc_fifo_st_t     s;
  dtc_fifo_st_t     next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign out_valid = (s.cnt != '0);
  assign push      = in_valid && s.rdy;
  assign pop       = out_valid && out_ready;
  assign in_ready  = s.rdy;
  assign out_data  = mem[s.rp];

  // ==========================================================================
  // pointers wrap naturally because depth is a power of two
  always_comb begin
    next_s     = s;
    next_s.wp  = push ? s.wp + 1'b1 : s.wp;
    next_s.rp  = pop ? s.rp + 1'b1 : s.rp;
    next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    next_s.rdy = (next_s.cnt != (AW + 1)'(DEPTH)); // full is registered
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset, only written on an accepted push
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end

endmodule : dtc_fifo

// *** hdl/dtc_ctrl.sv ***
// dram cycle controller: init, column-first refresh, page reads and writes
`timescale 1ns/1ns
module dtc_ctrl
  import dtc_pkg::*;
#(
  parameter int INIT_PAUSE_CYC = INIT_PAUSE_DFLT,
  parameter int RAS_MAX_CYC    = RAS_MAX_DFLT
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // request stream into the fifo
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire dtc_req_t   req,
  // read data return
  output logic            rd_valid,
  output logic [3:0]      rd_data,
  // status
  output logic            init_done,
  // dram pins
  output dtc_pins_t       dram,
  input  wire logic [3:0] data_pins_in
);

  // close the page early enough that one more column never overruns
  localparam int RAS_LIMIT = RAS_MAX_CYC - RD_CAS_CYC - 8;

  typedef struct packed {
    dtc_state_t st;
    logic [14:0] tmr;
    logic [13:0] ras_cnt;
    logic [2:0]  cas_age;
    logic [10:0] ref_cnt;
    logic        ref_pend;
    logic [3:0]  init_left;
    logic        init_done;
    logic        page_open;
    logic [8:0]  open_row;
    logic        cur_wr;
    dtc_pins_t   pins;
    logic        rd_valid;
    logic [3:0]  rd_data;
  } dtc_regs_t;

  dtc_regs_t s;
  dtc_regs_t next_s;
  dtc_req_t  head;
  logic      head_valid;
  logic      pop;
  logic      go_col;
  logic      cbr_start;
  logic      ref_tick;
  logic      page_hit;
  logic      must_close;
  logic [3:0] pin_val;

  // ==========================================================================
  // request buffer; its registered ready is the source's back-pressure
  dtc_fifo #(
    .WIDTH ($bits(dtc_req_t)),
    .DEPTH (16)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // data pins come from outside the clock domain
  dtc_sync #(
    .W (4)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (data_pins_in),
    .val     (pin_val)
  );

  // ==========================================================================
  // sequencer
  always_comb begin
    next_s          = s;
    next_s.rd_valid = 1'b0;
    go_col          = 1'b0;
    cbr_start       = 1'b0;
    pop             = 1'b0;
    page_hit        = s.page_open && (head.row == s.open_row);
    must_close      = 1'b0;
    // timers: tmr free-running, ras_cnt counts only while row strobe low, both ages saturate
    next_s.tmr      = s.tmr + 15'h0001;
    next_s.ras_cnt  = (s.pins.ras_n || (&s.ras_cnt)) ? s.ras_cnt
                      : s.ras_cnt + 14'h0001;
    next_s.cas_age  = (&s.cas_age) ? s.cas_age : s.cas_age + 3'h1;
    // one refresh per row slot of the window, after the pause
    ref_tick        = (s.st != ST_PAUSE)
                      && (s.ref_cnt == 11'(REF_INT_CYC - 1));
    if (s.st == ST_PAUSE || ref_tick) begin
      next_s.ref_cnt = 11'h000;
    end else begin
      next_s.ref_cnt = s.ref_cnt + 11'h001;
    end

    case (s.st)
      ST_PAUSE: begin
        // both strobes sit high from reset through the whole pause
        if (s.tmr >= 15'(INIT_PAUSE_CYC - 1)) begin
          next_s.st  = ST_IDLE;
          next_s.tmr = 15'h0000;
        end
      end
      ST_IDLE: begin
        if (s.init_left != 4'h0 || s.ref_pend) begin
          // column strobe first; precharge already gave it its high time
          next_s.pins.cas_n = 1'b0;
          next_s.st         = ST_CBR_CAS;
          next_s.tmr        = 15'h0000;
          cbr_start         = 1'b1;
        end else if (head_valid) begin
          // row address settles a full cycle before the row strobe
          next_s.pins.multiplexed_address = head.row;
          next_s.st                       = ST_ROW;
        end
      end
      ST_ROW: begin
        next_s.pins.ras_n = 1'b0;
        next_s.ras_cnt    = 14'h0000;
        next_s.open_row   = s.pins.multiplexed_address;
        next_s.page_open  = 1'b1;
        next_s.tmr        = 15'h0000;
        next_s.st         = ST_RAS_ACT;
      end
      ST_RAS_ACT: begin
        // hold row address, then column setup; column falls a cycle later
        if (s.tmr >= 15'(ROW_WAIT - 1)) begin
          go_col = 1'b1;
        end
      end
      ST_COL_SET: begin
        // page cycle spacing counted from the previous column fall
        if (s.cas_age >= 3'(PC_CYC - 1)) begin
          next_s.pins.cas_n = 1'b0;
          next_s.cas_age    = 3'h0;
          next_s.tmr        = 15'h0000;
          next_s.st         = ST_COL_LOW;
        end
      end
      ST_COL_LOW: begin
        // reads wait out row access plus overshoot and the pin synchroniser
        if ((s.cur_wr && s.tmr >= 15'(WR_CAS_CYC - 1))
            || (!s.cur_wr && s.tmr >= 15'(RD_CAS_CYC - 1))) begin
          next_s.pins.cas_n          = 1'b1;
          next_s.pins.we_n           = 1'b1;
          next_s.pins.oe_n           = 1'b1;
          next_s.pins.data_pins_oe_n = 1'b1;
          next_s.rd_valid            = !s.cur_wr;
          next_s.rd_data             = s.cur_wr ? s.rd_data
                                       : pin_val;
          next_s.tmr                 = 15'h0000;
          next_s.st                  = ST_COL_HI;
        end
      end
      ST_COL_HI: begin
        must_close = s.ref_pend || (s.ras_cnt >= 14'(RAS_LIMIT))
                     || (head_valid && !page_hit);
        // column precharge also covers gate-off to new write data
        if (s.tmr >= 15'(GAP_CYC - 1)) begin
          if (!must_close && head_valid) begin
            go_col = 1'b1;
          end else if (must_close
                       && s.ras_cnt >= 14'(RAS_MIN_CYC - 1)) begin
            next_s.pins.ras_n = 1'b1;
            next_s.page_open  = 1'b0;
            next_s.tmr        = 15'h0000;
            next_s.st         = ST_PRECHG;
          end
        end
      end
      ST_PRECHG: begin
        if (s.tmr >= 15'(PRE_CYC - 1)) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_CBR_CAS: begin
        if (s.tmr >= 15'(CSR_CYC - 1)) begin
          next_s.pins.ras_n = 1'b0;
          next_s.ras_cnt    = 14'h0000;
          next_s.tmr        = 15'h0000;
          next_s.st         = ST_CBR_RAS;
        end
      end
      ST_CBR_RAS: begin
        // column strobe stays low the whole row pulse, well past its hold
        if (s.tmr >= 15'(CBR_LOW_CYC - 1)) begin
          next_s.pins.ras_n = 1'b1;
          next_s.pins.cas_n = 1'b1;
          next_s.tmr        = 15'h0000;
          next_s.st         = ST_PRECHG;
        end
      end
      default: begin
        next_s.pins = PINS_RESET;
        next_s.st   = ST_IDLE;
      end
    endcase

    // column setup: address, strobes and data one cycle ahead of the fall;
    // only plain reads and early writes, so no read-modify-write spacing
    if (go_col) begin
      next_s.pins.multiplexed_address = head.col;
      next_s.pins.we_n                = !head.write;
      next_s.pins.oe_n                = head.write;
      next_s.pins.data_pins_out       = head.wdata;
      next_s.pins.data_pins_oe_n      = !head.write;
      next_s.cur_wr                   = head.write;
      next_s.tmr                      = 15'h0000;
      next_s.st                       = ST_COL_SET;
      pop                             = 1'b1;
    end

    // a tick landing on the servicing cycle is kept: set wins
    if (cbr_start && s.init_left != 4'h0) begin
      next_s.init_left = s.init_left - 4'h1;
    end
    next_s.ref_pend = ref_tick
                      || (s.ref_pend
                          && !(cbr_start && s.init_left == 4'h0));
    if (s.st == ST_IDLE && s.init_left == 4'h0) begin
      next_s.init_done = 1'b1;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s           <= '0;
      s.st        <= ST_PAUSE;
      s.cas_age   <= 3'h7;
      s.init_left <= 4'(INIT_CBR_COUNT);
      s.pins      <= PINS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign dram      = s.pins;
  assign rd_valid  = s.rd_valid;
  assign rd_data   = s.rd_data;
  assign init_done = s.init_done;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  pause_quiet_a: assert property (
    s.st == ST_PAUSE |-> dram.ras_n && dram.cas_n)
    else $error("strobe active during power-up pause");

  read_we_a: assert property (
    !dram.cas_n && !dram.oe_n |-> dram.we_n)
    else $error("write strobe low during a read column");

  ras_cas_gap_a: assert property (
    $fell(dram.cas_n) && !dram.ras_n |-> s.ras_cnt >= RCD_CYC)
    else $error("column strobe fell too soon after row strobe");

  cas_first_a: assert property (
    $fell(dram.cas_n) && dram.ras_n |-> s.st == ST_CBR_CAS)
    else $error("column strobe fell with row high outside refresh");

  cbr_order_a: assert property (
    $fell(dram.cas_n) && dram.ras_n |=> $fell(dram.ras_n))
    else $error("refresh row strobe did not follow column strobe");

  cbr_hold_a: assert property (
    $fell(dram.ras_n) && !dram.cas_n |-> (!dram.cas_n) [*2])
    else $error("refresh column strobe released too early");

  page_space_a: assert property (
    $fell(dram.cas_n) |=> (!$fell(dram.cas_n)) [*4])
    else $error("page column cycles closer than 40 ns");

  cas_prech_a: assert property (
    $fell(dram.cas_n) && !dram.ras_n
      |-> $past(dram.cas_n, 1) && $past(dram.cas_n, 2))
    else $error("column precharge shorter than 10 ns");

  write_lead_a: assert property (
    $rose(dram.cas_n) && !$past(dram.we_n) |-> !$past(dram.we_n, 2))
    else $error("write strobe low too briefly before column rise");

  gate_data_a: assert property (
    $fell(dram.data_pins_oe_n)
      |-> $past(dram.oe_n, 1) && $past(dram.oe_n, 2))
    else $error("write data driven too soon after gate off");

  bus_release_a: assert property (
    !dram.oe_n |-> dram.data_pins_oe_n)
    else $error("data pins driven while output gate on");

  ras_bound_a: assert property (
    !dram.ras_n |-> s.ras_cnt < RAS_MAX_CYC)
    else $error("row strobe low beyond its maximum");

  ras_width_a: assert property (
    $rose(dram.ras_n) |-> $past(s.ras_cnt) >= RAS_MIN_CYC - 1)
    else $error("row strobe pulse shorter than minimum");

  ref_served_a: assert property (
    $rose(s.ref_pend) |-> ##[1:300] !s.ref_pend)
    else $error("pending refresh not serviced in time");

  read_done_c:  cover property (rd_valid);
  write_col_c:  cover property ($fell(dram.cas_n) && !dram.we_n);
  cbr_c:        cover property ($fell(dram.ras_n) && !dram.cas_n);
  page_hit_c:   cover property ($fell(dram.cas_n) && s.ras_cnt > 14'h0010);

endmodule : dtc_ctrl

// *** sim/dtc_dram_model.sv ***
// behavioural dram device with a timing watch on the controller strobes
`timescale 1ns/1ns
module dtc_dram_model
  import dtc_pkg::*;
(
  // controller pins and resolved data
  input  wire dtc_pins_t  dram,
  input  wire logic [3:0] pin,
  // device output drive
  output logic [3:0]      drive,
  output logic            drive_en,
  // refresh count and timing faults
  output int              ref_cnt,
  output int              viol
);
  logic [3:0] mem [int];
  logic [8:0] row;
  logic [8:0] col;
  logic       cbr = 1'b0;
  time        t_rf = 0, t_cf = 0, t_cr = 0, t_wf = 0, t_go = 0;
  initial begin
    ref_cnt = 0;
    viol = 0;
    drive = 4'h0;
  end
  // outputs wake for reads only; an early write keeps them released
  assign drive_en = !dram.cas_n && !dram.oe_n
                    && dram.we_n && !cbr;
  // column already low at row fall selects the internal counter
  always @(negedge dram.ras_n) begin
    t_rf = $time;
    cbr = !dram.cas_n;
    if (cbr) ref_cnt++;
    else row = dram.multiplexed_address;
  end
  // column fall: latch column, take early write data, watch spacing
  always @(negedge dram.cas_n) begin
    if ($time - t_cr < CPN_NS) viol++;
    if (!dram.ras_n && $time - t_rf < RCD_MIN_NS) viol++;
    if (!dram.ras_n && $time - t_cf < PC_NS) viol++;
    t_cf = $time;
    col = dram.multiplexed_address;
    if (!dram.ras_n && !dram.we_n) mem[{row, col}] = pin;
  end
  always @(negedge dram.we_n) t_wf = $time;
  // strobes rise together, so leads are judged at the write strobe rise
  always @(posedge dram.we_n)
    if (t_wf > 0 && $time - t_wf < RWL_NS) viol++;
  always @(posedge dram.cas_n) begin
    if (cbr && $time - t_rf < CHR_NS) viol++;
    t_cr = $time;
  end
  always @(posedge dram.ras_n) begin
    if ($time - t_rf > RAS_MAX_NS) viol++;
    if (!cbr && t_rf > 0 && $time - t_cf < 30) viol++;
  end
  always @(posedge dram.oe_n) t_go = $time;
  // two drivers on the data pins would fight
  always @(negedge dram.data_pins_oe_n)
    if (drive_en || $time - t_go < OED_NS) viol++;
  // access waits for the later of the row and column paths
  always @(posedge drive_en) begin
    if (!dram.data_pins_oe_n) viol++;
    drive = ~drive;
    #((t_rf + RAC_NS > $time + 30) ? t_rf + RAC_NS - $time : 30);
    drive = mem.exists({row, col}) ? mem[{row, col}]
            : 4'h0;
  end
endmodule : dtc_dram_model

// *** sim/tb_dtc_ctrl.sv ***
// self-checking bench: device model, fifo fill, page and random traffic
`timescale 1ns/1ns
module tb_dtc_ctrl;
  import dtc_pkg::*;
  localparam int PAUSE = 20;
  localparam int RMAX  = 40;
  logic        sys_clk;
  logic        rst;
  logic        req_valid;
  logic        req_ready;
  dtc_req_t    req;
  logic        rd_valid;
  logic [3:0]  rd_data;
  logic        init_done;
  dtc_pins_t   dram;
  logic [3:0]  pin;
  logic [3:0]  drive;
  logic        drive_en;
  int          ref_cnt, viol, n_errors, checked, up, first_ras, gap, last_ref;
  logic [3:0]  shadow [int];
  logic [3:0]  expq [$];
  logic [31:0] lfsr;
  // released pins show the inverse of the last device value
  assign pin = !dram.data_pins_oe_n ? dram.data_pins_out
             : drive_en ? drive : ~drive;
  dtc_ctrl #(.INIT_PAUSE_CYC(PAUSE), .RAS_MAX_CYC(RMAX)) u_dtc_ctrl (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .dram(dram),
    .data_pins_in(pin));
  dtc_dram_model u_dtc_dram_model (.dram(dram), .pin(pin), .drive(drive),
    .drive_en(drive_en), .ref_cnt(ref_cnt), .viol(viol));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf
  function automatic logic [3:0] exp_rd(input logic [17:0] a);
    return shadow.exists(a) ? shadow[a] : 4'h0;
  endfunction : exp_rd
  // page columns with both boundaries
  function automatic logic [8:0] pc(input int i);
    return i == 0 ? 9'h000 : i == 15 ? 9'h1FF : 9'(i * 7);
  endfunction : pc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // offer one request, hold it until the edge that takes it
  task automatic send(input logic w, input logic [8:0] r,
                      input logic [8:0] c, input logic [3:0] d);
    int k;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{write: w, row: r, col: c, wdata: d};
    for (k = 0; k < 3000 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    if (k == 3000) begin
      n_errors++;
      wrap_up();
    end
    @(posedge sys_clk);
    if (w) shadow[{r, c}] = d;
    else expq.push_back(exp_rd({r, c}));
  endtask : send
  always @(negedge sys_clk) up = rst ? 0 : up + 1;
  always @(negedge dram.ras_n) if (first_ras == 0) first_ras = up;
  always @(posedge init_done) begin
    chk(first_ras >= PAUSE, 1);
    chk(ref_cnt, 8);
  end
  // read data returns in request order
  always @(negedge sys_clk)
    if (rd_valid === 1'b1)
      chk(rd_data, expq.size() > 0 ? expq.pop_front() : 4'hX);
  // a long stretch without refresh once running is a fault
  always @(negedge sys_clk) begin
    gap = (ref_cnt != last_ref || init_done !== 1'b1) ? 0 : gap + 1;
    last_ref = ref_cnt;
    if (gap == 2001 + RMAX + 40) chk(gap, 0);
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    int i;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lfsr = 32'hE51E;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    // fill the fifo while the device still pauses, then see refusal
    for (i = 0; i < 16; i++) send(1'b1, 9'h155, pc(i), 4'(i));
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk(req_ready, 1'b0);
    chk(init_done, 1'b0);
    // same page read back, column boundaries included
    for (i = 0; i < 16; i++) send(1'b0, 9'h155, pc(i), 4'h0);
    // random mix of hits, misses and idle gaps
    for (i = 0; i < 150; i++) begin
      lfsr = lf(lfsr);
      send(lfsr[0], {7'h00, lfsr[2:1]}, {4'h0, lfsr[7:3]}, lfsr[11:8]);
      if (lfsr[13:12] == 2'h0) begin
        @(negedge sys_clk);
        req_valid = 1'b0;
        repeat (lfsr[16:14]) @(negedge sys_clk);
      end
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (4500) @(negedge sys_clk);
    chk(ref_cnt >= 10, 1);
    chk(expq.size(), 0);
    chk(viol, 0);
    wrap_up();
  end
endmodule : tb_dtc_ctrl
